// File: rtl/dprp_pkg.sv
// Package for the debug port repeat and power handshake block.
// Assumes one clock domain (core_clk) and an APB register slave.
package dprp_pkg;

  // Register map (byte addresses)
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'h04;
  localparam logic [7:0] APREQ_ADDR = 8'h08;
  localparam logic [7:0] APDATA_ADDR = 8'h0c;

  // Control and status field positions
  localparam int CNT_LSB = 12;
  localparam int CNT_MSB = 23;
  localparam int ERR_BIT = 1;
  localparam int CMP_BIT = 4;
  localparam int MODE_LSB = 2;
  localparam int MASK_LSB = 8;
  localparam int MASK_MSB = 11;
  localparam int DBG_REQ_BIT = 28;
  localparam int DBG_ACK_BIT = 29;
  localparam int SYS_REQ_BIT = 30;
  localparam int SYS_ACK_BIT = 31;

  // Request register field positions
  localparam int REQ_WRITE_BIT = 0;
  localparam int REQ_BUSY_BIT = 1;

  localparam logic [31:0] CTRL_STATUS_RESET = 32'h0000_0000;
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [11:0] CNT_ONE = 12'h001;
  localparam logic [3:0] MASK_RESET = 4'hf;

  // Transfer modes
  typedef enum logic [1:0] {
    DPRP_MODE_NORMAL = 2'b00,
    DPRP_MODE_VERIFY = 2'b01,
    DPRP_MODE_COMPARE = 2'b10
  } dprp_mode_t;

  // Request towards the access port
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] data;
  } dprp_apreq_t;

  // Answer from the access port
  typedef struct packed {
    logic done;
    logic error;
    logic [31:0] data;
  } dprp_apresp_t;

endpackage

// File: rtl/dprp_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a slow handshake level from another domain.
`timescale 1ns/1ps
module dprp_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1;

  // Only the second stage reads stage1
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

// File: rtl/dprp_top.sv
// Repeat counter and power request/ack handshake of the debug port.
// Assumes APB master on core_clk and an access port answering with
// a one-cycle done pulse per request; power acks may be asynchronous.
`timescale 1ns/1ps
// How it works
// - Twelve-bit repeat counter in status bits 23:12
// - Count N issues N plus one transactions
// - Counter stops at zero, never reloads
// - Decrement after each successful transaction
// - No repeat on zero count or sticky flags
// - Stopped sequence keeps last successful count
// - Repeated writes reuse the first data value
// - Counter also repeats pushed compare reads
// - Bit 28 requests debug power, 29 shows ack
// - Bit 30 requests system power, 31 shows ack
// - Register lives in always-on domain
// - Request low asks removal, ack drops
// - Sticky compare cancels outstanding repeats
module dprp_top
  import dprp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dprp_apreq_t apReq,
  input wire dprp_apresp_t apResp,
  output logic debugDomainPowerRequest,
  input wire logic debugDomainPowerAck,
  output logic systemDomainPowerRequest,
  input wire logic systemDomainPowerAck
);

  typedef enum logic [1:0] {
    DPRP_IDLE = 2'b00,
    DPRP_ISSUE = 2'b01,
    DPRP_WAIT = 2'b10
  } dprp_state_t;

  dprp_state_t state;
  logic [11:0] repeatCounter;
  logic stickyErrorFlag;
  logic stickyCompareFlag;
  dprp_mode_t transferModeField;
  logic [3:0] compareByteMask;
  logic dbgAckSync;
  logic sysAckSync;
  logic reqWrite;
  logic [31:0] reqData;
  logic [31:0] lastRead;
  logic access;
  logic wrEn;
  logic cmpHit;
  logic txnOk;
  logic moreRepeats;

  assign access = psel && penable;
  // Writes land only at the edge where the master also sees pready
  assign wrEn = access && pwrite && pready;

  function automatic logic masked_equal(input logic [31:0] a,
                                        input logic [31:0] b,
                                        input logic [3:0] m);
    logic eq;
    eq = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (m[i] && (a[i*8 +: 8] != b[i*8 +: 8])) begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction

  // Acks come from an asynchronous power controller
  dprp_sync dbgSyncInst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(debugDomainPowerAck),
    .syncOut(dbgAckSync)
  );

  dprp_sync sysSyncInst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(systemDomainPowerAck),
    .syncOut(sysAckSync)
  );

  // A pushed write turns into a read; compare its data with the request
  always_comb begin
    cmpHit = 1'b0;
    if (apResp.done && !apResp.error) begin
      if (transferModeField == DPRP_MODE_COMPARE) begin
        cmpHit = masked_equal(apResp.data, reqData, compareByteMask);
      end else if (transferModeField == DPRP_MODE_VERIFY) begin
        cmpHit = !masked_equal(apResp.data, reqData, compareByteMask);
      end
    end
  end

  assign txnOk = (state == DPRP_WAIT) && apResp.done && !apResp.error
    && !cmpHit;
  // Repeat only while counter nonzero and no sticky flag
  assign moreRepeats = (repeatCounter != CNT_ZERO) && !stickyErrorFlag
    && !stickyCompareFlag;

  // Pushed modes make every access a read of the data register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= DPRP_IDLE;
      apReq <= '0;
    end else begin
      case (state)
        DPRP_IDLE: begin
          apReq.valid <= 1'b0;
          if (wrEn && paddr == APREQ_ADDR && !stickyErrorFlag
              && !stickyCompareFlag) begin
            state <= DPRP_ISSUE;
          end
        end
        DPRP_ISSUE: begin
          apReq.valid <= 1'b1;
          apReq.write <= reqWrite
            && (transferModeField == DPRP_MODE_NORMAL);
          apReq.data <= reqData;
          state <= DPRP_WAIT;
        end
        DPRP_WAIT: begin
          apReq.valid <= 1'b0;
          if (apResp.done) begin
            if (txnOk && moreRepeats) begin
              state <= DPRP_ISSUE;
            end else begin
              state <= DPRP_IDLE;
            end
          end
        end
        default: begin
          state <= DPRP_IDLE;
        end
      endcase
    end
  end

  // Software write loads the count; hardware only counts down to zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      repeatCounter <= CNT_ZERO;
    end else if (txnOk && moreRepeats) begin
      repeatCounter <= repeatCounter - CNT_ONE;
    end else if (wrEn && paddr == CTRL_STATUS_ADDR && state == DPRP_IDLE) begin
      repeatCounter <= pwdata[CNT_MSB:CNT_LSB];
    end
  end

  // Sticky flags: hardware set wins over a write-one clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stickyErrorFlag <= 1'b0;
      stickyCompareFlag <= 1'b0;
    end else begin
      if (state == DPRP_WAIT && apResp.done && apResp.error) begin
        stickyErrorFlag <= 1'b1;
      end else if (wrEn && paddr == CTRL_STATUS_ADDR && pwdata[ERR_BIT]) begin
        stickyErrorFlag <= 1'b0;
      end
      if (state == DPRP_WAIT && cmpHit) begin
        stickyCompareFlag <= 1'b1;
      end else if (wrEn && paddr == CTRL_STATUS_ADDR && pwdata[CMP_BIT]) begin
        stickyCompareFlag <= 1'b0;
      end
    end
  end

  // Control fields and power requests; always-on, reset only at power-on
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      transferModeField <= DPRP_MODE_NORMAL;
      compareByteMask <= MASK_RESET;
      debugDomainPowerRequest <= 1'b0;
      systemDomainPowerRequest <= 1'b0;
    end else if (wrEn && paddr == CTRL_STATUS_ADDR) begin
      transferModeField <= dprp_mode_t'(pwdata[MODE_LSB +: 2]);
      compareByteMask <= pwdata[MASK_MSB:MASK_LSB];
      debugDomainPowerRequest <= pwdata[DBG_REQ_BIT];
      systemDomainPowerRequest <= pwdata[SYS_REQ_BIT];
    end
  end

  // Request register: direction and the one data value all repeats use
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reqWrite <= 1'b0;
      reqData <= 32'h0000_0000;
    end else if (wrEn && paddr == APREQ_ADDR && state == DPRP_IDLE) begin
      reqWrite <= pwdata[REQ_WRITE_BIT];
    end else if (wrEn && paddr == APDATA_ADDR && state == DPRP_IDLE) begin
      reqData <= pwdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lastRead <= 32'h0000_0000;
    end else if (state == DPRP_WAIT && apResp.done) begin
      lastRead <= apResp.data;
    end
  end

  // APB: one wait state, access answered with pready on second cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        if (paddr == CTRL_STATUS_ADDR) begin
          prdata[SYS_ACK_BIT] <= sysAckSync;
          prdata[SYS_REQ_BIT] <= systemDomainPowerRequest;
          prdata[DBG_ACK_BIT] <= dbgAckSync;
          prdata[DBG_REQ_BIT] <= debugDomainPowerRequest;
          prdata[CNT_MSB:CNT_LSB] <= repeatCounter;
          prdata[MASK_MSB:MASK_LSB] <= compareByteMask;
          prdata[CMP_BIT] <= stickyCompareFlag;
          prdata[MODE_LSB +: 2] <= transferModeField;
          prdata[ERR_BIT] <= stickyErrorFlag;
        end else if (paddr == APREQ_ADDR) begin
          prdata[REQ_WRITE_BIT] <= reqWrite;
          prdata[REQ_BUSY_BIT] <= (state != DPRP_IDLE);
        end else if (paddr == APDATA_ADDR) begin
          prdata <= lastRead;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  sequence seqGoodDone;
    state == DPRP_WAIT && apResp.done && !apResp.error && !cmpHit;
  endsequence

  sequence seqStopDone;
    state == DPRP_WAIT && apResp.done && (apResp.error || cmpHit);
  endsequence

  AST_DECREMENT: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    seqGoodDone ##0 moreRepeats
    |=> repeatCounter == $past(repeatCounter) - CNT_ONE)
    else $error("counter did not decrement");
  AST_ZERO_STAYS: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    repeatCounter == CNT_ZERO && !(wrEn && paddr == CTRL_STATUS_ADDR)
    |=> repeatCounter == CNT_ZERO)
    else $error("counter left zero by itself");
  AST_REPEAT: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    seqGoodDone ##0 moreRepeats |=> state == DPRP_ISSUE ##1 apReq.valid)
    else $error("repeat not issued");
  AST_NO_REPEAT: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state == DPRP_WAIT && apResp.done && !moreRepeats
    |=> state == DPRP_IDLE && $stable(repeatCounter))
    else $error("repeat despite stop condition");
  AST_START_REFUSED: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state == DPRP_IDLE && (stickyErrorFlag || stickyCompareFlag)
    |=> state == DPRP_IDLE)
    else $error("sequence started with a sticky flag set");
  AST_KEEP_COUNT: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    seqStopDone |=> $stable(repeatCounter))
    else $error("count changed on failed transaction");
  AST_CANCEL: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state == DPRP_WAIT && cmpHit |=> stickyCompareFlag && state == DPRP_IDLE)
    else $error("compare hit did not cancel");
  AST_SAME_DATA: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    apReq.valid |-> apReq.data == reqData)
    else $error("repeat data differs");
  AST_PUSHED_READ: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    apReq.valid && transferModeField != DPRP_MODE_NORMAL |-> !apReq.write)
    else $error("pushed mode issued a write");
  AST_DBG_REQ: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    wrEn && paddr == CTRL_STATUS_ADDR
    |=> debugDomainPowerRequest == $past(pwdata[DBG_REQ_BIT])
    && systemDomainPowerRequest == $past(pwdata[SYS_REQ_BIT]))
    else $error("power request not written");
  AST_STATUS_READ: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    psel && penable && !pready && paddr == CTRL_STATUS_ADDR
    |=> prdata[CNT_MSB:CNT_LSB] == $past(repeatCounter))
    else $error("status read missed the remaining count");
  AST_ACK_SYNC: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ##2 dbgAckSync == $past(debugDomainPowerAck, 2))
    else $error("ack not two-flop delayed");
  AST_SYS_ACK_SYNC: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ##2 sysAckSync == $past(systemDomainPowerAck, 2))
    else $error("system ack not two-flop delayed");

endmodule

// File: tb/debug_port_repeat_and_power_handshake_tb.sv
// Bench for the repeat counter and power handshake over APB.
// Assumes the partner model stands on the access port and power side.
`timescale 1ns/1ps
module debug_port_repeat_and_power_handshake_tb
  import dprp_pkg::*;
;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, lastErr;
  logic debugDomainPowerRequest, debugDomainPowerAck, clrStats;
  logic systemDomainPowerRequest, systemDomainPowerAck, dataDiff, sawWrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, hitVal;
  logic [3:0] errAt, hitAt, nTrans;
  dprp_apreq_t apReq;
  dprp_apresp_t apResp;
  int bad_count = 0;
  int checks = 0;

  dprp_top dprp_top_i (.core_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .apReq, .apResp,
    .debugDomainPowerRequest, .debugDomainPowerAck,
    .systemDomainPowerRequest, .systemDomainPowerAck);
  dprp_partner_model dprp_partner_model_i (.core_clk, .sys_rst, .apReq,
    .apResp, .debugDomainPowerRequest, .debugDomainPowerAck,
    .systemDomainPowerRequest, .systemDomainPowerAck, .clrStats, .errAt,
    .hitAt, .hitVal, .nTrans, .dataDiff, .sawWrite);

  always #2 core_clk = ~core_clk;

  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      bad_count++;
      final_report();
    end
    r = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // One request with count, mode, error and hit positions, then checks
  task automatic run(input logic [11:0] cnt, input logic [1:0] mode,
    input logic [3:0] ea, ha, expN, input logic [11:0] expCnt,
    input logic [31:0] expFl);
    int n;
    errAt <= ea;
    hitAt <= ha;
    clrStats <= 1'h1;
    apb(1'h1, CTRL_STATUS_ADDR, {8'h10, cnt, 4'hf, 4'h0, mode, 2'h0});
    clrStats <= 1'h0;
    apb(1'h1, APDATA_ADDR, hitVal);
    check("power pair", {debugDomainPowerRequest, debugDomainPowerAck},
          2'h3);
    apb(1'h1, APREQ_ADDR, 32'h1);
    // Busy only shows once the start write has landed, so poll at least once
    n = 0;
    do begin
      apb(1'h0, APREQ_ADDR, 32'h0);
      n++;
    end while (r[REQ_BUSY_BIT] !== 1'h0 && n < 60);
    if (r[REQ_BUSY_BIT] !== 1'h0) begin
      bad_count++;
      final_report();
    end
    apb(1'h0, CTRL_STATUS_ADDR, 32'h0);
    check("transactions", nTrans, expN);
    check("counter", r[CNT_MSB:CNT_LSB], expCnt);
    check("sticky flags", r & 32'h12, expFl);
    check("data reuse", dataDiff, 1'h0);
    check("write dir", sawWrite, mode == 2'h0 && expN != 4'h0);
    check("slave ok", lastErr, 1'h0);
    if (expN != 4'h0) begin
      apb(1'h0, APDATA_ADDR, 32'h0);
      check("read data", r, (expN == ha) ? hitVal : ~hitVal);
    end
  endtask

  initial begin
    core_clk = 1'h0;
    sys_rst = 1'h1;
    {psel, penable, pwrite, clrStats} = 4'h0;
    {paddr, pwdata, errAt, hitAt} = 48'h0;
    hitVal = 32'hc3a5_0f96;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'h0;
    apb(1'h0, CTRL_STATUS_ADDR, 32'h0);
    check("ctrl reset", r & 32'hffff_f0ff, 32'h0);
    apb(1'h1, CTRL_STATUS_ADDR, 32'h5000_0f00);
    @(posedge core_clk);
    check("req out", {debugDomainPowerRequest, systemDomainPowerRequest},
          2'h3);
    repeat (12) @(posedge core_clk);
    apb(1'h0, CTRL_STATUS_ADDR, 32'h0);
    check("power up", r, 32'hf000_0f00);
    apb(1'h1, CTRL_STATUS_ADDR, 32'h1000_0f00);
    repeat (12) @(posedge core_clk);
    apb(1'h0, CTRL_STATUS_ADDR, 32'h0);
    check("sys down", r, 32'h3000_0f00);
    // Ack was seen low above, so the request may rise again
    apb(1'h1, CTRL_STATUS_ADDR, 32'h5000_0f00);
    repeat (12) @(posedge core_clk);
    apb(1'h0, CTRL_STATUS_ADDR, 32'h0);
    check("sys up again", r, 32'hf000_0f00);
    apb(1'h0, 8'h40, 32'h0);
    check("unmapped", lastErr, 1'h1);
    run(12'h2, 2'h0, 4'h0, 4'h0, 4'h3, 12'h0, 32'h0);
    run(12'h0, 2'h0, 4'h0, 4'h0, 4'h1, 12'h0, 32'h0);
    run(12'h5, 2'h0, 4'h0, 4'h0, 4'h6, 12'h0, 32'h0);
    run(12'h3, 2'h0, 4'h2, 4'h0, 4'h2, 12'h2, 32'h2);
    run(12'h3, 2'h0, 4'h0, 4'h0, 4'h0, 12'h3, 32'h2);
    apb(1'h1, CTRL_STATUS_ADDR, 32'h1000_0f12);
    run(12'h3, 2'h2, 4'h0, 4'h2, 4'h2, 12'h2, 32'h10);
    apb(1'h1, CTRL_STATUS_ADDR, 32'h1000_0f12);
    run(12'h3, 2'h1, 4'h0, 4'h2, 4'h1, 12'h3, 32'h10);
    final_report();
  end
endmodule

// File: tb/dprp_partner_model.sv
// Access port and power controller facing the repeat block.
// Assumes one clock; the bench clears the statistics between sequences.
`timescale 1ns/1ps
module dprp_partner_model
  import dprp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire dprp_apreq_t apReq,
  output dprp_apresp_t apResp,
  input wire logic debugDomainPowerRequest,
  output logic debugDomainPowerAck,
  input wire logic systemDomainPowerRequest,
  output logic systemDomainPowerAck,
  input wire logic clrStats,
  input wire logic [3:0] errAt,
  input wire logic [3:0] hitAt,
  input wire logic [31:0] hitVal,
  output logic [3:0] nTrans,
  output logic dataDiff,
  output logic sawWrite
);
  logic [2:0] dbgOn;
  logic [2:0] sysOn;
  logic [2:0] waitCnt;
  logic busy;
  logic [31:0] prev;

  // Domains become active a few cycles after their request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dbgOn <= 3'h0;
      sysOn <= 3'h0;
    end else begin
      dbgOn <= {dbgOn[1:0], debugDomainPowerRequest};
      sysOn <= {sysOn[1:0], systemDomainPowerRequest};
    end
  end

  // Ack drops with the request even while the domain is still up
  assign debugDomainPowerAck =
    debugDomainPowerRequest & dbgOn[2];
  assign systemDomainPowerAck =
    systemDomainPowerRequest & sysOn[2];

  // Odd transactions answer at once, even ones late; data toggles when idle
  always_ff @(posedge core_clk) begin
    apResp.done <= 1'h0;
    apResp.error <= 1'h0;
    apResp.data <= ~apResp.data;
    if (sys_rst || clrStats) begin
      nTrans <= 4'h0;
      dataDiff <= 1'h0;
      sawWrite <= 1'h0;
      busy <= 1'h0;
      apResp.data <= 32'h0;
    end else if (apReq.valid) begin
      busy <= 1'h1;
      waitCnt <= nTrans[0] ? 3'h4 : 3'h0;
      nTrans <= nTrans + 4'h1;
      prev <= apReq.data;
      if (nTrans != 4'h0 && apReq.data !== prev) begin
        dataDiff <= 1'h1;
      end
      if (apReq.write) begin
        sawWrite <= 1'h1;
      end
    end else if (busy && waitCnt != 3'h0) begin
      waitCnt <= waitCnt - 3'h1;
    end else if (busy) begin
      busy <= 1'h0;
      apResp.done <= 1'h1;
      apResp.error <= (nTrans == errAt);
      apResp.data <= (nTrans == hitAt) ? hitVal : ~hitVal;
    end
  end
endmodule
